// ==== core/afe_pkg.sv ====
// Constants and types for the black level calibration control block
// Behaviour
// - Blanking low stops sampler, outputs blanking word
// - Frame: two nulls, four address, ten data
// - Serial port active only while select low
// - Polarity pin selects active serial clock edge
// - Reset pin and power-on restore all defaults
// - Software reset bit acts like hardware reset
// - Standby from pin low or power-down bit
// - Registers stay writable during standby
// - Clamp pulse low starts line calibration
// - Average black, steer fine DAC to target
// - Beyond fine range, coarse steps one code
// - Coarse step weight is gain times n
// - Rolling average weight from 1 to 1/128
// - Out-of-limit pixels replaced by previous pixel
// - Quick mode: first line unlimited, weight one
// - Pixels per line are 2 to N, N 0..6
// - Auto mode resumes from held DAC values
// - Gain code limited to 0 through 767
package afe_pkg;
  localparam int          DATA_W      = 10;
  localparam int          FRAME_BITS  = 16;
  localparam int          SYNC_W      = 19;
  // Register addresses within the four-bit field
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_CTRL2  = 4'h1;
  localparam logic [3:0]  ADDR_TARGET = 4'h2;
  localparam logic [3:0]  ADDR_BLANK  = 4'h3;
  localparam logic [3:0]  ADDR_HOT    = 4'h4;
  localparam logic [3:0]  ADDR_COLD   = 4'h5;
  localparam logic [3:0]  ADDR_GAIN   = 4'h6;
  localparam logic [3:0]  ADDR_COARSE = 4'h7;
  localparam logic [3:0]  ADDR_FINE   = 4'h8;
  // Control register fields
  localparam int          CTRL_SRST   = 0;
  localparam int          CTRL_PD     = 1;
  localparam int          CTRL_MANUAL = 2;
  // Second control register fields
  localparam int          C2_WSH_LO   = 0;
  localparam int          C2_QUICK    = 3;
  localparam int          C2_NEXP_LO  = 4;
  // Values after reset
  localparam logic [9:0]  CTRL_RST    = 10'h000;
  localparam logic [9:0]  CTRL2_RST   = 10'h064;
  localparam logic [9:0]  TARGET_RST  = 10'h040;
  localparam logic [9:0]  BLANK_RST   = 10'h000;
  localparam logic [9:0]  HOT_RST     = 10'h3FF;
  localparam logic [9:0]  COLD_RST    = 10'h000;
  localparam logic [9:0]  GAIN_RST    = 10'h000;
  // Calibration limits
  localparam logic [9:0]  GAIN_MAX    = 10'h2FF;
  localparam logic [17:0] GAIN_RECIP  = 18'h000F5;
  localparam int          FINE_MAX    = 225;
  localparam int          COARSE_MAX  = 127;
  localparam logic [2:0]  NEXP_MAX    = 3'h6;
  localparam int          FRAC_W      = 7;

  typedef enum logic [1:0] {CAL_IDLE, CAL_ACCUM, CAL_UPDATE} cal_state_e;
endpackage : afe_pkg

// ==== core/black_level_ctrl.sv ====
// Serial configuration, blanking, standby and black level calibration
`timescale 1ns/1ps
module black_level_ctrl
  import afe_pkg::*;
#(
  parameter int DEPTH = 2
)(
  // Clock and reset pin
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Serial configuration pins
  input  wire logic              sclk_pin,
  input  wire logic              cs_n,
  input  wire logic              serial_data_in,
  input  wire logic              serial_clock_polarity_pin,
  // Timing and mode pins
  input  wire logic              standby_n,
  input  wire logic              input_blanking_n,
  input  wire logic              black_clamp_pulse_n,
  input  wire logic              frame_start,
  input  wire logic              conversion_clock,
  input  wire logic [DATA_W-1:0] adc_code,
  // Output word stream
  output logic [DATA_W-1:0]      out_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  // Analog and status controls
  output logic                   cds_enable,
  output logic                   standby_active,
  output logic signed [7:0]      coarse_offset_dac,
  output logic signed [9:0]      fine_offset_dac,
  output logic [DATA_W-1:0]      gain_amplifier,
  output logic                   overrun
);
  if (DEPTH < 2) $error("black_level_ctrl needs DEPTH of at least 2");

  // Coarse step size in converter LSBs, gain linearised as 2^(code/133.8)
  function automatic logic [8:0] coarse_weight(input logic [9:0] code);
    logic [9:0]  c;
    logic [17:0] prod;
    logic [3:0]  nx;
    logic [17:0] w;
    c    = (code > GAIN_MAX) ? GAIN_MAX : code;
    prod = 18'(c) * GAIN_RECIP;
    nx   = (c < 10'h040) ? 4'h8 : ((c < 10'h060) ? 4'h3 : 4'h2);
    w    = 18'((18'(9'h100 + 9'(prod[14:7])) << prod[17:15]) * 18'(nx)) >> 9;
    coarse_weight = w[8:0];
  endfunction : coarse_weight

  // Two-stage synchroniser for every input pin except clk, arst_n and out_ready
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [3:0]        prev_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      prev_reg <= '0;
    end
    else
    begin
      s1_reg   <= {adc_code, frame_start, conversion_clock, black_clamp_pulse_n, input_blanking_n,
                   standby_n, serial_clock_polarity_pin, serial_data_in, cs_n, sclk_pin};
      s2_reg   <= s1_reg;
      prev_reg <= {s2_reg[8], s2_reg[7], s2_reg[6], s2_reg[0]};
    end
  end

  // Named views and edges of synchronised pins
  wire              sck_s     = s2_reg[0];
  wire              cs_s      = s2_reg[1];
  wire              sdi_s     = s2_reg[2];
  wire              pol_s     = s2_reg[3];
  wire              standby_n_n_s  = s2_reg[4];
  wire              blank_n_s = s2_reg[5];
  wire [DATA_W-1:0] pix_s     = s2_reg[18:9];
  wire              sck_edge  = pol_s ? (sck_s && !prev_reg[0]) : (!sck_s && prev_reg[0]);
  wire              clamp_fall = !s2_reg[6] && prev_reg[1];
  wire              pix_stb   = s2_reg[7] && !prev_reg[2];
  wire              frame_rise = s2_reg[8] && !prev_reg[3];

  // Serial shifter state
  logic [4:0]            bit_cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic                  wr_stb_reg;
  logic                  srst_reg;
  wire                   shift_en = !cs_s && sck_edge && (bit_cnt_reg != 5'(FRAME_BITS));
  wire [FRAME_BITS-1:0]  shift_next = {shift_reg[FRAME_BITS-2:0], sdi_s};
  wire [3:0]             wr_addr = shift_reg[13:10];
  wire [9:0]             wr_data = shift_reg[9:0];

  // Shift MSB first, strobe once the sixteenth bit is in
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
      wr_stb_reg  <= 1'b0;
    end
    else
    begin
      wr_stb_reg <= shift_en && (bit_cnt_reg == 5'(FRAME_BITS - 1)) && !srst_reg;
      if (cs_s || srst_reg) bit_cnt_reg <= '0;
      else if (shift_en)
      begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        shift_reg   <= shift_next;
      end
    end
  end

  // Write decode, active in standby as well
  wire wr_ctrl   = wr_stb_reg && (wr_addr == ADDR_CTRL);
  wire wr_coarse = wr_stb_reg && (wr_addr == ADDR_COARSE);
  wire wr_fine   = wr_stb_reg && (wr_addr == ADDR_FINE);

  // Configuration registers
  logic [9:0] ctrl_reg;
  logic [9:0] ctrl2_reg;
  logic [9:0] target_reg;
  logic [9:0] blank_reg;
  logic [9:0] hot_reg;
  logic [9:0] cold_reg;
  logic [9:0] gain_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n || srst_reg)
    begin
      ctrl_reg   <= CTRL_RST;
      ctrl2_reg  <= CTRL2_RST;
      target_reg <= TARGET_RST;
      blank_reg  <= BLANK_RST;
      hot_reg    <= HOT_RST;
      cold_reg   <= COLD_RST;
      gain_reg   <= GAIN_RST;
    end
    else if (wr_stb_reg)
    begin
      if (wr_ctrl) ctrl_reg <= wr_data & ~(10'h001 << CTRL_SRST);
      if (wr_addr == ADDR_CTRL2) ctrl2_reg <= wr_data;
      if (wr_addr == ADDR_TARGET) target_reg <= wr_data;
      if (wr_addr == ADDR_BLANK) blank_reg <= wr_data;
      if (wr_addr == ADDR_HOT) hot_reg <= wr_data;
      if (wr_addr == ADDR_COLD) cold_reg <= wr_data;
      if (wr_addr == ADDR_GAIN) gain_reg <= (wr_data > GAIN_MAX) ? GAIN_MAX : wr_data;
    end
  end

  // Software reset pulse, one cycle after the write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) srst_reg <= 1'b0;
    else srst_reg <= wr_ctrl && wr_data[CTRL_SRST] && !srst_reg;
  end

  // Mode decode
  wire       manual    = ctrl_reg[CTRL_MANUAL];
  wire [2:0] nexp      = (ctrl2_reg[6:4] > NEXP_MAX) ? NEXP_MAX : ctrl2_reg[6:4];
  wire [5:0] last_pix  = 6'((7'h01 << nexp) - 7'h01);
  assign standby_active = !standby_n_n_s || ctrl_reg[CTRL_PD];
  assign cds_enable     = blank_n_s && !standby_active;
  assign gain_amplifier = gain_reg;

  // Calibration state
  cal_state_e        cal_state;
  logic [5:0]        cal_cnt_reg;
  logic [15:0]       sum_reg;
  logic [9:0]        prev_pix_reg;
  logic [16:0]       avg_reg;
  logic              first_line_reg;
  logic              quick_reg;
  logic signed [7:0] coarse_reg;
  logic signed [9:0] fine_reg;

  // Pixel limiting and averaging arithmetic
  wire               in_limits = (pix_s <= hot_reg) && (pix_s >= cold_reg);
  wire [9:0]         pix_used  = (quick_reg || in_limits) ? pix_s : prev_pix_reg;
  wire [9:0]         line_avg  = 10'(sum_reg >> nexp);
  wire [2:0]         wshift    = quick_reg ? 3'h0 : ctrl2_reg[2:0];
  wire signed [17:0] avg_diff  = $signed({1'b0, line_avg, 7'h00}) - $signed({1'b0, avg_reg});
  wire [16:0]        avg_next  = 17'($signed({1'b0, avg_reg}) + (avg_diff >>> wshift));
  wire signed [11:0] cal_err   = $signed({2'b00, target_reg}) - $signed({2'b00, avg_next[16:7]});
  wire signed [11:0] fine_try  = 12'(fine_reg) + cal_err;
  wire               too_high  = fine_try > 12'sd225;
  wire               too_low   = fine_try < -12'sd225;
  wire signed [11:0] cweight   = $signed({3'b000, coarse_weight(gain_reg)});
  wire signed [11:0] fine_step = too_high ? (fine_try - cweight) : (too_low ? (fine_try + cweight) : fine_try);
  wire signed [11:0] fine_sat  = (fine_step > 12'sd225) ? 12'sd225 : ((fine_step < -12'sd225) ? -12'sd225 : fine_step);
  wire               c_up      = too_high && (coarse_reg != 8'sd127);
  wire               c_dn      = too_low && (coarse_reg != -8'sd127);

  // Line sequencer: start on clamp, collect 2^N pixels, then update
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n || srst_reg)
    begin
      cal_state      <= CAL_IDLE;
      cal_cnt_reg    <= '0;
      sum_reg        <= '0;
      prev_pix_reg   <= '0;
      avg_reg        <= {TARGET_RST, 7'h00};
      first_line_reg <= 1'b0;
      quick_reg      <= 1'b0;
    end
    else
    begin
      if (frame_rise) first_line_reg <= 1'b1;
      else if (cal_state == CAL_UPDATE) first_line_reg <= 1'b0;
      case (cal_state)
        CAL_IDLE:
        begin
          if (clamp_fall && !manual && !standby_active)
          begin
            cal_state   <= CAL_ACCUM;
            cal_cnt_reg <= '0;
            sum_reg     <= '0;
            quick_reg   <= first_line_reg && ctrl2_reg[C2_QUICK];
          end
        end
        CAL_ACCUM:
        begin
          if (manual || standby_active) cal_state <= CAL_IDLE;
          else if (pix_stb)
          begin
            sum_reg      <= sum_reg + 16'(pix_used);
            prev_pix_reg <= pix_used;
            cal_cnt_reg  <= cal_cnt_reg + 6'h01;
            if (cal_cnt_reg == last_pix) cal_state <= CAL_UPDATE;
          end
        end
        CAL_UPDATE:
        begin
          avg_reg   <= avg_next;
          cal_state <= CAL_IDLE;
        end
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  // Offset DACs: written by host, stepped by the loop from held values
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n || srst_reg)
    begin
      coarse_reg <= '0;
      fine_reg   <= '0;
    end
    else if (wr_coarse || wr_fine)
    begin
      if (wr_coarse) coarse_reg <= $signed(wr_data[7:0]);
      if (wr_fine) fine_reg <= $signed(wr_data);
    end
    else if (cal_state == CAL_UPDATE && !manual)
    begin
      fine_reg <= 10'(fine_sat);
      if (c_up) coarse_reg <= coarse_reg + 8'sd1;
      else if (c_dn) coarse_reg <= coarse_reg - 8'sd1;
    end
  end
  assign coarse_offset_dac = coarse_reg;
  assign fine_offset_dac   = fine_reg;

  // Output words: blanking value replaces converted data
  stream_if #(.WIDTH(DATA_W)) fill_s ();
  stream_if #(.WIDTH(DATA_W)) drain_s ();
  logic overrun_reg;
  assign fill_s.valid  = pix_stb && !standby_active;
  assign fill_s.data   = blank_n_s ? pix_s : blank_reg;
  assign drain_s.ready = out_ready;
  assign out_data      = drain_s.data;
  assign out_valid     = drain_s.valid;
  assign overrun       = overrun_reg;

  // Sticky flag for a word arriving with the buffer full
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n || srst_reg) overrun_reg <= 1'b0;
    else if (fill_s.valid && !fill_s.ready) overrun_reg <= 1'b1;
  end

  word_buffer #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_buf (
    .clk    (clk),
    .arst_n (arst_n),
    .flush  (srst_reg),
    .fill   (fill_s),
    .drain  (drain_s)
  );

  // Checks on the block's own behaviour
  property p_blank;
    @(posedge clk) disable iff (!arst_n) !blank_n_s |-> !cds_enable && fill_s.data == blank_reg;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking not applied");
  property p_standby;
    @(posedge clk) disable iff (!arst_n) (!standby_n_n_s || ctrl_reg[CTRL_PD]) |-> standby_active && !cds_enable;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");
  property p_commit;
    @(posedge clk) disable iff (!arst_n) wr_stb_reg |-> bit_cnt_reg == 5'(FRAME_BITS) && $past(shift_en);
  endproperty
  a_commit: assert property (p_commit) else $error("write before sixteenth bit");
  property p_srst;
    @(posedge clk) disable iff (!arst_n) srst_reg |=> target_reg == TARGET_RST && ctrl_reg == CTRL_RST;
  endproperty
  a_srst: assert property (p_srst) else $error("software reset missed");
  property p_standby_n_wr;
    @(posedge clk) disable iff (!arst_n)
      standby_active && wr_stb_reg && wr_addr == ADDR_TARGET && !srst_reg |=> target_reg == $past(wr_data);
  endproperty
  a_standby_n_wr: assert property (p_standby_n_wr) else $error("write lost in standby");
  property p_start;
    @(posedge clk) disable iff (!arst_n)
      cal_state == CAL_IDLE && clamp_fall && !manual && !standby_active && !srst_reg |=> cal_state == CAL_ACCUM;
  endproperty
  a_start: assert property (p_start) else $error("clamp did not start calibration");
  property p_count;
    @(posedge clk) disable iff (!arst_n)
      cal_state == CAL_ACCUM && pix_stb && cal_cnt_reg == last_pix && !manual && !standby_active && !srst_reg
      |=> cal_state == CAL_UPDATE ##1 cal_state == CAL_IDLE;
  endproperty
  a_count: assert property (p_count) else $error("wrong pixel count");
  property p_coarse;
    @(posedge clk) disable iff (!arst_n)
      cal_state == CAL_UPDATE && !manual && !wr_coarse && !wr_fine && !srst_reg
      |=> (coarse_reg - $past(coarse_reg)) inside {-8'sd1, 8'sd0, 8'sd1} && fine_reg <= 10'sd225 && fine_reg >= -10'sd225;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse step or fine range wrong");
endmodule : black_level_ctrl

// ==== core/stream_if.sv ====
// Valid/ready word carrier between the control block and its buffer
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 10);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== core/word_buffer.sv ====
// Small FIFO holding output words through a receiver stall; words arriving while it is full are dropped
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic flush,
  // Fill and drain sides
  stream_if.snk     fill,
  stream_if.src     drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2) $error("word_buffer needs DEPTH of at least 2");

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              do_push = fill.valid && fill.ready;
  wire              do_pop  = drain.valid && drain.ready;

  // Honest full and empty flags
  assign fill.ready  = (count_reg != (AW+1)'(DEPTH));
  assign drain.valid = (count_reg != '0);
  assign drain.data  = mem_reg[rd_ptr_reg];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  // Storage writes
  always_ff @(posedge clk)
  begin
    if (do_push) mem_reg[wr_ptr_reg] <= fill.data;
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (do_push) wr_ptr_reg <= bump(wr_ptr_reg);
      if (do_pop) rd_ptr_reg <= bump(rd_ptr_reg);
      count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : word_buffer

// ==== sim/serial_host.sv ====
// Host model that writes configuration frames over the three-wire port
`timescale 1ns/1ps
module serial_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Frame request
  input  wire logic        start,
  input  wire logic        short_frame,
  input  wire logic [15:0] word,
  input  wire logic        pol,
  output logic             busy,
  // Serial pins
  output logic             sclk,
  output logic             cs_n,
  output logic             sdo
);
  logic [7:0]  cnt;
  logic [15:0] sh_reg;
  logic [7:0]  last;

  // Short frame stops after eight bits
  assign last = short_frame ? 8'h40 : 8'h80;

  // Eight clocks a bit: four idle level, four active level
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      busy <= 1'b0;
      cs_n <= 1'b1;
      sclk <= ~pol;
      sdo <= 1'b0;
      cnt <= 8'h00;
      sh_reg <= 16'h0000;
    end
    else if (!busy)
    begin
      sclk <= ~pol;
      sdo <= ~sdo; // Released data line keeps moving
      if (start)
      begin
        busy <= 1'b1;
        cs_n <= 1'b0;
        cnt <= 8'h00;
        sh_reg <= word;
      end
    end
    else
    begin
      cnt <= cnt + 8'h01;
      if (cnt >= last)
      begin
        cs_n <= 1'b1;
        sclk <= ~pol;
        sdo <= ~sdo;
        busy <= (cnt != last + 8'h07);
      end
      else if (cnt[2:0] == 3'h0)
      begin
        sclk <= ~pol; // Back to idle level before the next bit
        sdo  <= sh_reg[15];
      end
      else if (cnt[2:0] == 3'h4)
        sclk <= pol;
      else if (cnt[2:0] == 3'h7)
        sh_reg <= sh_reg << 1;
    end
endmodule : serial_host

// ==== sim/tb_top.sv ====
// Self-checking bench for the black level calibration block
`timescale 1ns/1ps
module tb_top;
  import afe_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, pol = 1'b1, standby_n = 1'b1, input_blanking_n = 1'b1;
  logic black_clamp_pulse_n = 1'b1, frame_start = 1'b0, conversion_clock = 1'b0, out_ready = 1'b1;
  logic hstart = 1'b0, hshort = 1'b0, busy, sclk_pin, cs_n, sdi, out_valid, cds_enable, standby_active, overrun;
  logic [15:0]       hword = 16'h0000;
  logic [9:0]        adc_code = 10'h000, out_data, gain_amplifier, g, bv;
  logic signed [9:0] fine_offset_dac;
  logic signed [7:0] coarse_offset_dac;
  logic [2:0]        cc = 3'h0;
  logic [9:0]        t = 10'h100;
  int                error_cnt = 0, tests_run = 0, f, c;

  serial_host host_u (.clk(clk), .arst_n(arst_n), .start(hstart), .short_frame(hshort), .word(hword),
    .pol(pol), .busy(busy), .sclk(sclk_pin), .cs_n(cs_n), .sdo(sdi));
  black_level_ctrl #(.DEPTH(2)) dut_u (.clk(clk), .arst_n(arst_n), .sclk_pin(sclk_pin), .cs_n(cs_n),
    .serial_data_in(sdi), .serial_clock_polarity_pin(pol), .standby_n(standby_n),
    .input_blanking_n(input_blanking_n), .black_clamp_pulse_n(black_clamp_pulse_n),
    .frame_start(frame_start), .conversion_clock(conversion_clock), .adc_code(adc_code),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .cds_enable(cds_enable),
    .standby_active(standby_active), .coarse_offset_dac(coarse_offset_dac),
    .fine_offset_dac(fine_offset_dac), .gain_amplifier(gain_amplifier), .overrun(overrun));

  // System clock and a conversion clock of eight system periods
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cc <= cc + 3'h1;
    conversion_clock <= cc[2];
  end

  task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk10

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // Gain register clamps oversized codes
  function automatic logic [9:0] gain_exp(input logic [9:0] v);
    return (v > GAIN_MAX) ? GAIN_MAX : v;
  endfunction : gain_exp

  // Next coarse and fine codes at gain code 0, coarse step worth four
  function automatic logic [19:0] step(input int fv, input int cv, input int e);
    int s;
    s = fv + e;
    if (s > FINE_MAX)
    begin
      cv++;
      s -= 4;
    end
    else if (s < -FINE_MAX)
    begin
      cv--;
      s += 4;
    end
    s = (s > FINE_MAX) ? FINE_MAX : ((s < -FINE_MAX) ? -FINE_MAX : s);
    return {10'(cv), 10'(s)};
  endfunction : step

  task automatic wr(input logic [3:0] a, input logic [9:0] d, input logic s = 1'b0);
    int n;
    hword <= {2'b00, a, d};
    hshort <= s;
    hstart <= 1'b1;
    @(posedge clk);
    hstart <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 300);
    chk1(busy, 1'b0);
    repeat (8) @(posedge clk);
  endtask : wr

  task automatic next_px;
    do @(posedge clk); while (cc != 3'h1);
  endtask : next_px

  // One black line of four pixels a,b,a,a, then compare the offset codes
  task automatic cal(input logic [9:0] a, input logic [9:0] b, input logic q, input int e);
    logic [19:0] ex;
    frame_start <= q;
    repeat (4) @(posedge clk);
    frame_start <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      next_px();
      adc_code <= (i == 1) ? b : a;
      black_clamp_pulse_n <= (i > 1);
    end
    repeat (24) @(posedge clk);
    ex = step(f, c, e);
    chk10(fine_offset_dac, ex[9:0]);
    chk10(10'(coarse_offset_dac), ex[19:10]);
    f = int'($signed(ex[9:0]));
    c = int'($signed(ex[19:10]));
  endtask : cal

  // Main sequence
  initial
  begin
    void'($urandom(13));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk10(gain_amplifier, GAIN_RST);
    chk1(standby_active, 1'b0);
    chk1(cds_enable, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      pol <= i[0];
      repeat (4) @(posedge clk);
      g = (i < 4) ? 10'($urandom % 768) : ((i == 4) ? GAIN_MAX : 10'h3FF);
      wr(ADDR_GAIN, g);
      chk10(gain_amplifier, gain_exp(g));
    end
    wr(ADDR_CTRL, 10'h001);
    chk10(gain_amplifier, GAIN_RST);
    wr(ADDR_CTRL, 10'h004);
    wr(ADDR_COARSE, 10'h005);
    wr(ADDR_FINE, 10'd200);
    chk10(fine_offset_dac, 10'd200);
    wr(ADDR_TARGET, t);
    wr(ADDR_HOT, t + 10'd40);
    wr(ADDR_COLD, t - 10'd40);
    wr(ADDR_CTRL2, 10'h02F);
    wr(ADDR_CTRL, 10'h000);
    f = 200;
    c = 5;
    cal(t, t, 1'b1, 0);
    cal(t + 10'd30, t + 10'd70, 1'b1, -40);
    cal(t - 10'd70, t - 10'd70, 1'b1, 70);
    wr(ADDR_CTRL2, 10'h020);
    cal(t + 10'd10, t + 10'd90, 1'b0, -10);
    wr(ADDR_CTRL2, 10'h021);
    cal(t + 10'd30, t - 10'd60, 1'b0, -20);
    standby_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk1(standby_active, 1'b1);
    chk1(cds_enable, 1'b0);
    g = 10'($urandom % 768);
    wr(ADDR_GAIN, g);
    wr(ADDR_TARGET, t);
    chk10(gain_amplifier, g);
    standby_n <= 1'b1;
    wr(ADDR_CTRL, 10'h002);
    chk1(standby_active, 1'b1);
    wr(ADDR_CTRL, 10'h000);
    chk1(standby_active, 1'b0);
    wr(ADDR_GAIN, 10'h000, 1'b1);
    chk10(gain_amplifier, g);
    wr(4'h9, 10'h000);
    chk10(gain_amplifier, g);
    bv = 10'($urandom);
    wr(ADDR_BLANK, bv);
    next_px();
    input_blanking_n <= 1'b0;
    repeat (8) @(posedge clk);
    out_ready <= 1'b0;
    repeat (40) @(posedge clk);
    chk1(cds_enable, 1'b0);
    chk1(overrun, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      chk1(out_valid, 1'b1);
      chk10(out_data, bv);
      out_ready <= 1'b1;
      @(posedge clk);
      out_ready <= 1'b0;
      @(posedge clk);
    end
    input_blanking_n <= 1'b1;
    out_ready <= 1'b1;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk10(gain_amplifier, GAIN_RST);
    chk1(overrun, 1'b0);
    conclude();
  end

  // Watchdog against a hang
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    conclude();
  end
endmodule : tb_top
